// >>> logic/mci_core.sv
// Purpose: command interpreter for direct and stored-program operation
// Assumes: host and program ports on the same clock; pins synchronised here
// Notes: program store, parameter memories and motor lie outside
`default_nettype none
`include "mci_params.svh"
// Operation
// [RQ1] Decode motion codes 1,2,3,4,30,31,32.
// [RQ2] Motion codes run from host and from stored program.
// [RQ3] Decode parameter codes 5,6,9,10,11,12; axis and global kinds.
// [RQ4] Parameter codes run in both modes.
// [RQ5] Flow codes 20-24,27,28 run only in the stored program.
// [RQ6] Output set and input read drive and sample the ports, both modes.
// [RQ7] Decode calculation codes 19,33,34,35,39.
// [RQ8] Program-mode value results load the accumulator.
// [RQ9] X register loads from the accumulator.
// [RQ10] Host value queries leave the accumulator untouched.
// [RQ11] Decode interrupt codes 25,26,37,38.
// [RQ12] Each source has its own numbered vector.
// [RQ13] Number 255 is global enable; dispatch needs both enables.
// [RQ14] Enabled source with valid vector diverts flow to its handler.
// [RQ15] Accumulator, X and flags are saved before the handler.
// [RQ16] No other interrupt while a handler runs.
// [RQ17] Return from interrupt restores context and resumes.
// [RQ18] Interrupt settings go via global parameter bank 3.
// [RQ19] Handlers end with return; program must not fall into them.
// [RQ20] Unknown codes change nothing and report an error. Code reports only for host commands; in the program they are skipped silently.
module mci_core (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Host direct command
  input wire logic host_valid,
  input wire logic [7:0] host_op,
  input wire logic [7:0] host_type,
  input wire logic [7:0] host_bank,
  input wire logic [31:0] host_value,
  output logic host_reply_valid,
  output logic [7:0] host_status,
  output logic [31:0] host_reply,
  // Stored program fetch
  input wire logic run,
  input wire logic [7:0] prog_op,
  input wire logic [7:0] prog_type,
  input wire logic [7:0] prog_bank,
  input wire logic [31:0] prog_value,
  output logic [15:0] pc,
  output logic running,
  output logic in_handler,
  // Parameter and motion back end
  output logic be_valid,
  output logic [7:0] be_op,
  output logic [7:0] be_type,
  output logic [7:0] be_bank,
  output logic [31:0] be_value,
  input wire logic be_done,
  input wire logic [31:0] be_result,
  // Interrupt events and I/O pins
  input wire logic [13:0] irq_event,
  input wire logic [5:0] in_pins,
  output logic [7:0] out_pins,
  // Calculation state
  output logic [31:0] accu,
  output logic [31:0] x_value
);
  logic [31:0] accu_reg, accu_next;
  logic [31:0] x_reg;
  logic [1:0] flags_reg, flags_next;
  logic [15:0] pc_reg;
  logic run_reg;
  logic hand_reg;
  logic [31:0] sv_accu_reg, sv_x_reg;
  logic [1:0] sv_flags_reg;
  logic [15:0] sv_pc_reg;
  logic gie_reg;
  logic [15:0] stack_reg [`MCI_STACK_DEPTH];
  logic [2:0] sp_reg;
  logic [7:0] out_reg;
  logic [5:0] in_s1_reg, in_s2_reg;
  mci_pkg::mci_state_t state_reg;
  logic from_host_reg;
  logic [7:0] op_reg, type_reg, bank_reg;
  logic [31:0] val_reg;
  logic rvalid_reg;
  logic [7:0] rstat_reg;
  logic [31:0] rdata_reg;
  logic bevalid_reg;
  logic [31:0] beval_reg;
  logic [13:0] src_pend, src_armed, src_en_set, src_en_clr, src_vload, src_taken;
  logic [15:0] src_vec [`MCI_NUM_SRC];
  logic irq_req;
  logic [3:0] irq_idx;
  logic [7:0] src_num [`MCI_NUM_SRC];
  logic known, flow_op, value_op, needs_be, exec_now;

  // Source numbers of the interrupt slots
  assign src_num = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F, 8'h15, 8'h1B, 8'h1C,
                     8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C};

  // Two-flop synchroniser on input pins
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      in_s1_reg <= 6'h00;
      in_s2_reg <= 6'h00;
    end else begin
      in_s1_reg <= in_pins;
      in_s2_reg <= in_s1_reg;
    end
  end

  // Decode classes of the latched opcode
  always_comb begin
    known = 1'b1;
    flow_op = 1'b0;
    value_op = 1'b0;
    needs_be = 1'b0;
    case (op_reg)
      // [RQ1] motion decode, with the axis and global parameter reads
      `MCI_OP_ROTATE_CW, `MCI_OP_ROTATE_CCW, `MCI_OP_MOTOR_HALT,
      `MCI_OP_MOVE_TO_POSITION, `MCI_OP_STORE_COORDINATE,
      `MCI_OP_CAPTURE_COORDINATE: needs_be = 1'b1;
      `MCI_OP_GET_COORDINATE, `MCI_OP_GET_AXIS_PARAM,
      `MCI_OP_GET_GLOBAL_PARAM: begin
        needs_be = 1'b1;
        value_op = 1'b1;
      end
      // [RQ3] parameter decode
      `MCI_OP_SET_AXIS_PARAM, `MCI_OP_SET_GLOBAL_PARAM,
      `MCI_OP_STORE_GLOBAL_PARAM, `MCI_OP_RESTORE_GLOBAL_PARAM: needs_be = 1'b1;
      // [RQ7] calculation decode, with output, input and interrupt codes
      `MCI_OP_ACCU_TO_AXIS_PARAM, `MCI_OP_ACCU_TO_GLOBAL_PARAM,
      `MCI_OP_ACCU_TO_COORDINATE: needs_be = 1'b1;
      `MCI_OP_CONSTANT_A, `MCI_OP_CONSTANT_A_WITH_X, `MCI_OP_SET_OUTPUT,
      `MCI_OP_IRQ_ENABLE, `MCI_OP_IRQ_DISABLE, `MCI_OP_SET_IRQ_VECTOR: known = 1'b1;
      `MCI_OP_GET_INPUT: value_op = 1'b1;
      // [RQ5] flow codes marked program-only
      `MCI_OP_COMPARE, `MCI_OP_JUMP_CONDITIONAL, `MCI_OP_JUMP_ALWAYS,
      `MCI_OP_CALL_SUBROUTINE, `MCI_OP_RETURN_SUBROUTINE, `MCI_OP_WAIT,
      `MCI_OP_END_PROGRAM, `MCI_OP_RETURN_FROM_IRQ: flow_op = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Executes this cycle: known, legal for mode, and not a back-end op
  assign exec_now = state_reg == mci_pkg::MCI_EXEC && known &&
                    !(flow_op && from_host_reg) && !needs_be;

  // Interrupt request: lowest slot wins; blocked in handler or host command
  // [RQ13] both enables required
  always_comb begin
    irq_req = 1'b0;
    irq_idx = 4'h0;
    for (int i = `MCI_NUM_SRC - 1; i >= 0; i--) begin
      if (src_pend[i] && src_armed[i]) begin
        irq_req = 1'b1;
        irq_idx = 4'(i);
      end
    end
    // [RQ16] no nesting
    irq_req = irq_req && gie_reg && !hand_reg && run_reg &&
              state_reg == mci_pkg::MCI_IDLE && !host_valid;
  end

  // Per-slot controls from enable, disable and vector commands
  always_comb begin
    for (int i = 0; i < `MCI_NUM_SRC; i++) begin
      src_en_set[i] = exec_now && op_reg == `MCI_OP_IRQ_ENABLE && type_reg == src_num[i];
      src_en_clr[i] = exec_now && op_reg == `MCI_OP_IRQ_DISABLE && type_reg == src_num[i];
      src_vload[i] = exec_now && op_reg == `MCI_OP_SET_IRQ_VECTOR && type_reg == src_num[i];
      src_taken[i] = irq_req && irq_idx == 4'(i);
    end
  end

  // [RQ12] one slot per numbered source
  for (genvar g = 0; g < `MCI_NUM_SRC; g++) begin : g_src
    mci_irq_src u_src (
      .clock(clock),
      .arst_n(arst_n),
      .enable_set(src_en_set[g]),
      .enable_clr(src_en_clr[g]),
      .vector_load(src_vload[g]),
      .vector_in(val_reg[15:0]),
      .event_pulse(irq_event[g]),
      .taken(src_taken[g]),
      .pending(src_pend[g]),
      .armed(src_armed[g]),
      .vector(src_vec[g])
    );
  end

  // Command sequencer: host has priority; back-end ops wait for done
  // [RQ2] [RQ4] both sources feed one path
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= mci_pkg::MCI_IDLE;
      from_host_reg <= 1'b0;
      op_reg <= 8'h00;
      type_reg <= 8'h00;
      bank_reg <= 8'h00;
      val_reg <= 32'h0000_0000;
      bevalid_reg <= 1'b0;
      beval_reg <= 32'h0000_0000;
    end else begin
      bevalid_reg <= 1'b0;
      case (state_reg)
        mci_pkg::MCI_IDLE: begin
          if (host_valid) begin
            from_host_reg <= 1'b1;
            {op_reg, type_reg, bank_reg, val_reg} <=
              {host_op, host_type, host_bank, host_value};
            state_reg <= mci_pkg::MCI_EXEC;
          end else if (run_reg && run && !irq_req) begin
            from_host_reg <= 1'b0;
            {op_reg, type_reg, bank_reg, val_reg} <=
              {prog_op, prog_type, prog_bank, prog_value};
            state_reg <= mci_pkg::MCI_EXEC;
          end
        end
        mci_pkg::MCI_EXEC: begin
          if (known && needs_be) begin
            bevalid_reg <= 1'b1;
            // Registered so the back-end value comes straight from a flop
            beval_reg <= (op_reg == `MCI_OP_ACCU_TO_AXIS_PARAM ||
                          op_reg == `MCI_OP_ACCU_TO_GLOBAL_PARAM ||
                          op_reg == `MCI_OP_ACCU_TO_COORDINATE) ? accu_reg : val_reg;
            state_reg <= mci_pkg::MCI_WAIT;
          end else begin
            state_reg <= mci_pkg::MCI_IDLE;
          end
        end
        mci_pkg::MCI_WAIT: begin
          if (be_done) begin
            state_reg <= mci_pkg::MCI_IDLE;
          end
        end
        default: state_reg <= mci_pkg::MCI_IDLE;
      endcase
    end
  end

  // Accumulator and flags next value
  always_comb begin
    accu_next = accu_reg;
    flags_next = flags_reg;
    if (exec_now && !from_host_reg) begin
      case (op_reg)
        // [RQ7] arithmetic with constant and with X
        `MCI_OP_CONSTANT_A, `MCI_OP_CONSTANT_A_WITH_X: begin
          case (type_reg)
            `MCI_CONSTANT_A_ADD: accu_next = accu_reg + (op_reg == `MCI_OP_CONSTANT_A ? val_reg : x_reg);
            `MCI_CONSTANT_A_SUB: accu_next = accu_reg - (op_reg == `MCI_OP_CONSTANT_A ? val_reg : x_reg);
            `MCI_CONSTANT_A_AND: accu_next = accu_reg & (op_reg == `MCI_OP_CONSTANT_A ? val_reg : x_reg);
            `MCI_CONSTANT_A_OR: accu_next = accu_reg | (op_reg == `MCI_OP_CONSTANT_A ? val_reg : x_reg);
            `MCI_CONSTANT_A_LOAD: accu_next = op_reg == `MCI_OP_CONSTANT_A ? val_reg : x_reg;
            default: accu_next = accu_reg;
          endcase
          flags_next = {accu_next[31], accu_next == 32'h0000_0000};
        end
        // [RQ8] input read result to accumulator
        `MCI_OP_GET_INPUT: accu_next = {26'h000_0000, in_s2_reg};
        `MCI_OP_COMPARE: flags_next = {$signed(accu_reg) < $signed(val_reg), accu_reg == val_reg};
        default: accu_next = accu_reg;
      endcase
    end else if (state_reg == mci_pkg::MCI_WAIT && be_done && !from_host_reg && value_op) begin
      // [RQ8] back-end value result to accumulator
      accu_next = be_result;
    end
  end

  // Accumulator, X and flags with interrupt save/restore
  // [RQ10] host results never reach this path
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      accu_reg <= 32'h0000_0000;
      x_reg <= 32'h0000_0000;
      flags_reg <= 2'b00;
      sv_accu_reg <= 32'h0000_0000;
      sv_x_reg <= 32'h0000_0000;
      sv_flags_reg <= 2'b00;
    end else if (irq_req) begin
      // [RQ15] context save
      sv_accu_reg <= accu_reg;
      sv_x_reg <= x_reg;
      sv_flags_reg <= flags_reg;
    end else if (exec_now && !from_host_reg && op_reg == `MCI_OP_RETURN_FROM_IRQ && hand_reg) begin
      // [RQ17] context restore
      accu_reg <= sv_accu_reg;
      x_reg <= sv_x_reg;
      flags_reg <= sv_flags_reg;
    end else begin
      accu_reg <= accu_next;
      flags_reg <= flags_next;
      // [RQ9] X loads from accumulator
      if (exec_now && !from_host_reg && op_reg == `MCI_OP_CONSTANT_A_WITH_X &&
          type_reg == `MCI_CONSTANT_A_TO_X) begin
        x_reg <= accu_reg;
      end
    end
  end

  // Program counter, run state, subroutine stack and handler entry
  // [RQ14] divert to vector of the winning source
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= 16'h0000;
      run_reg <= 1'b0;
      hand_reg <= 1'b0;
      sv_pc_reg <= 16'h0000;
      sp_reg <= 3'h0;
      for (int i = 0; i < `MCI_STACK_DEPTH; i++) begin
        stack_reg[i] <= 16'h0000;
      end
    end else if (irq_req) begin
      sv_pc_reg <= pc_reg;
      pc_reg <= src_vec[irq_idx];
      hand_reg <= 1'b1;
    end else if (!run_reg) begin
      run_reg <= run;
      pc_reg <= 16'h0000;
    end else if (!run) begin
      run_reg <= 1'b0;
    end else if (state_reg == mci_pkg::MCI_IDLE && !host_valid) begin
      pc_reg <= pc_reg + 16'h0001;
    end else if (exec_now && !from_host_reg) begin
      // [RQ5] flow other than compare executes only here, program mode; compare sets the flags in the accumulator block
      case (op_reg)
        `MCI_OP_JUMP_ALWAYS: pc_reg <= val_reg[15:0];
        `MCI_OP_JUMP_CONDITIONAL: begin
          if ((type_reg == `MCI_COND_ZERO && flags_reg[0]) ||
              (type_reg == `MCI_COND_NZERO && !flags_reg[0])) begin
            pc_reg <= val_reg[15:0];
          end
        end
        `MCI_OP_CALL_SUBROUTINE: begin
          stack_reg[sp_reg] <= pc_reg;
          sp_reg <= sp_reg + 3'h1;
          pc_reg <= val_reg[15:0];
        end
        `MCI_OP_RETURN_SUBROUTINE: begin
          sp_reg <= sp_reg - 3'h1;
          pc_reg <= stack_reg[sp_reg - 3'h1];
        end
        `MCI_OP_END_PROGRAM: run_reg <= 1'b0;
        // [RQ19] relies on handler ending with return
        `MCI_OP_RETURN_FROM_IRQ: begin
          if (hand_reg) begin
            pc_reg <= sv_pc_reg;
            hand_reg <= 1'b0;
          end
        end
        default: pc_reg <= pc_reg;
      endcase
    end
  end

  // Global enable via number 255
  // [RQ13] global switch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gie_reg <= 1'b0;
    end else if (exec_now && type_reg == `MCI_IRQ_GLOBAL) begin
      if (op_reg == `MCI_OP_IRQ_ENABLE) begin
        gie_reg <= 1'b1;
      end else if (op_reg == `MCI_OP_IRQ_DISABLE) begin
        gie_reg <= 1'b0;
      end
    end
  end

  // Output port drive
  // [RQ6] set output in either mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= 8'h00;
    end else if (exec_now && op_reg == `MCI_OP_SET_OUTPUT) begin
      out_reg[type_reg[2:0]] <= val_reg[0];
    end
  end

  // Host reply; unknown or program-only codes answer with an error
  // [RQ20] reject and report
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rstat_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      rvalid_reg <= 1'b0;
      if (from_host_reg && state_reg == mci_pkg::MCI_EXEC && !(known && needs_be)) begin
        rvalid_reg <= 1'b1;
        rstat_reg <= !known ? `MCI_ST_BAD_OP : flow_op ? `MCI_ST_BAD_MODE : `MCI_ST_OK;
        // [RQ6] input sample returned
        rdata_reg <= op_reg == `MCI_OP_GET_INPUT ? {26'h000_0000, in_s2_reg} : 32'h0000_0000;
      end else if (from_host_reg && state_reg == mci_pkg::MCI_WAIT && be_done) begin
        rvalid_reg <= 1'b1;
        rstat_reg <= `MCI_ST_OK;
        rdata_reg <= be_result;
      end
    end
  end

  // Back end sees the latched command; [RQ18] bank 3 passes through
  assign be_valid = bevalid_reg;
  assign be_op = op_reg;
  assign be_type = type_reg;
  assign be_bank = bank_reg;
  assign be_value = beval_reg;
  assign host_reply_valid = rvalid_reg;
  assign host_status = rstat_reg;
  assign host_reply = rdata_reg;
  assign pc = pc_reg;
  assign running = run_reg;
  assign in_handler = hand_reg;
  assign out_pins = out_reg;
  assign accu = accu_reg;
  assign x_value = x_reg;

  // Checks
  host_accu_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ10]
    rvalid_reg && from_host_reg |-> accu_reg == $past(accu_reg))
    else $error("host command changed accumulator");
  no_nest_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ16]
    hand_reg |=> $stable(sv_pc_reg) && $stable(sv_accu_reg))
    else $error("nested interrupt");
  ctx_save_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ15]
    irq_req |=> sv_accu_reg == $past(accu_reg) && hand_reg)
    else $error("context not saved");
  bad_op_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ20]
    state_reg == mci_pkg::MCI_EXEC && from_host_reg && !known
    |=> rvalid_reg && rstat_reg == `MCI_ST_BAD_OP && $stable(accu_reg))
    else $error("unknown op not rejected");
  gie_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ13]
    !gie_reg |=> !$rose(hand_reg)) else $error("dispatch without global enable");
  host_flow_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ5]
    run_reg && state_reg == mci_pkg::MCI_EXEC && from_host_reg && flow_op
    |=> $stable(pc_reg))
    else $error("host flow op moved pc");
  x_load_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ9]
    exec_now && !from_host_reg && op_reg == `MCI_OP_CONSTANT_A_WITH_X &&
    type_reg == `MCI_CONSTANT_A_TO_X |=> x_reg == $past(accu_reg))
    else $error("x not loaded");
  vec_a: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
    irq_req |=> pc_reg == $past(src_vec[irq_idx])) else $error("bad vector");
  irq_c: cover property (@(posedge clock) disable iff (!arst_n) irq_req);
  host_c: cover property (@(posedge clock) disable iff (!arst_n) rvalid_reg);
  be_c: cover property (@(posedge clock) disable iff (!arst_n) bevalid_reg ##[1:20] be_done);
endmodule
`default_nettype wire

// >>> logic/mci_irq_src.sv
// Purpose: one interrupt source slot: enable, vector, pending latch
// Assumes: event pulse from same clock domain
// Notes: set wins over clear on the pending flag
`default_nettype none
module mci_irq_src (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Configuration
  input wire logic enable_set,
  input wire logic enable_clr,
  input wire logic vector_load,
  input wire logic [15:0] vector_in,
  // Event and service
  input wire logic event_pulse,
  input wire logic taken,
  output logic pending,
  output logic armed,
  output logic [15:0] vector
);
  logic enable_reg;
  logic valid_reg;
  logic [15:0] vector_reg;
  logic pend_reg;

  // Per-source enable bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enable_reg <= 1'b0;
    end else if (enable_set) begin
      enable_reg <= 1'b1;
    end else if (enable_clr) begin
      enable_reg <= 1'b0;
    end
  end

  // Vector storage, valid once defined
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vector_reg <= 16'h0000;
      valid_reg <= 1'b0;
    end else if (vector_load) begin
      vector_reg <= vector_in;
      valid_reg <= 1'b1;
    end
  end

  // Pending latch; a new event beats the service clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg <= 1'b0;
    end else if (event_pulse) begin
      pend_reg <= 1'b1;
    end else if (taken) begin
      pend_reg <= 1'b0;
    end
  end

  assign pending = pend_reg;
  assign armed = enable_reg & valid_reg;
  assign vector = vector_reg;
endmodule
`default_nettype wire

// >>> logic/mci_params.svh
// Purpose: constants for the motion command interpreter
// Assumes: included by bare name
// Notes: definitions only
`ifndef MCI_PARAMS_SVH
`define MCI_PARAMS_SVH
`define MCI_OP_ROTATE_CW 8'h01
`define MCI_OP_ROTATE_CCW 8'h02
`define MCI_OP_MOTOR_HALT 8'h03
`define MCI_OP_MOVE_TO_POSITION 8'h04
`define MCI_OP_SET_AXIS_PARAM 8'h05
`define MCI_OP_GET_AXIS_PARAM 8'h06
`define MCI_OP_SET_GLOBAL_PARAM 8'h09
`define MCI_OP_GET_GLOBAL_PARAM 8'h0A
`define MCI_OP_STORE_GLOBAL_PARAM 8'h0B
`define MCI_OP_RESTORE_GLOBAL_PARAM 8'h0C
`define MCI_OP_SET_OUTPUT 8'h0E
`define MCI_OP_GET_INPUT 8'h0F
`define MCI_OP_CONSTANT_A 8'h13
`define MCI_OP_COMPARE 8'h14
`define MCI_OP_JUMP_CONDITIONAL 8'h15
`define MCI_OP_JUMP_ALWAYS 8'h16
`define MCI_OP_CALL_SUBROUTINE 8'h17
`define MCI_OP_RETURN_SUBROUTINE 8'h18
`define MCI_OP_IRQ_ENABLE 8'h19
`define MCI_OP_IRQ_DISABLE 8'h1A
`define MCI_OP_WAIT 8'h1B
`define MCI_OP_END_PROGRAM 8'h1C
`define MCI_OP_STORE_COORDINATE 8'h1E
`define MCI_OP_GET_COORDINATE 8'h1F
`define MCI_OP_CAPTURE_COORDINATE 8'h20
`define MCI_OP_CONSTANT_A_WITH_X 8'h21
`define MCI_OP_ACCU_TO_AXIS_PARAM 8'h22
`define MCI_OP_ACCU_TO_GLOBAL_PARAM 8'h23
`define MCI_OP_SET_IRQ_VECTOR 8'h25
`define MCI_OP_RETURN_FROM_IRQ 8'h26
`define MCI_OP_ACCU_TO_COORDINATE 8'h27
`define MCI_IRQ_GLOBAL 8'hFF
`define MCI_IRQ_BANK 8'h03
`define MCI_NUM_SRC 14
`define MCI_STACK_DEPTH 8
`define MCI_ST_OK 8'h64
`define MCI_ST_BAD_OP 8'h02
`define MCI_ST_BAD_MODE 8'h06
`define MCI_CONSTANT_A_ADD 8'h00
`define MCI_CONSTANT_A_SUB 8'h01
`define MCI_CONSTANT_A_AND 8'h05
`define MCI_CONSTANT_A_OR 8'h06
`define MCI_CONSTANT_A_LOAD 8'h09
`define MCI_CONSTANT_A_TO_X 8'h0A
`define MCI_COND_ZERO 8'h00
`define MCI_COND_NZERO 8'h01
`endif

// >>> logic/mci_pkg.sv
// Purpose: shared types of the motion command interpreter
// Assumes: nothing
// Notes: types only; numbers live in the params header
`default_nettype none
package mci_pkg;
  typedef enum logic [1:0] {
    MCI_IDLE = 2'b00,
    MCI_EXEC = 2'b01,
    MCI_WAIT = 2'b10
  } mci_state_t;
endpackage
`default_nettype wire

// >>> tb/mci_far_model.sv
// Purpose: far-side model: back end responder and stored program
// Assumes: one clock shared with the interpreter
// Notes: result line toggles between answers so stale data is visible
`default_nettype none
`include "mci_params.svh"
module mci_far_model #(
  parameter int DELAY = 3
) (
  // Clock
  input wire logic clock,
  // Back end handshake
  input wire logic be_valid,
  output logic be_done,
  output logic [31:0] be_result,
  // Program store
  input wire logic [15:0] pc,
  output logic [7:0] prog_op,
  output logic [7:0] prog_type,
  output logic [7:0] prog_bank,
  output logic [31:0] prog_value
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0;
  initial be_done = 1'b0;
  initial be_result = 32'h0000_0000;
  // Answer each request after DELAY cycles; between answers the data is junk
  always @(posedge clock) begin
    be_done <= 1'b0;
    be_result <= ~be_result;
    if (be_valid) begin
      wait_cnt <= DELAY;
    end else if (wait_cnt == 1) begin
      be_done <= 1'b1;
      be_result <= 32'h1234_5678;
      wait_cnt <= 0;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
  // program ends before any handler
  // Load 5, copy to X, add 3, end; handler at 0x10 clobbers accu, then returns
  always_comb begin
    prog_bank = 8'h00;
    case (pc)
      16'h0000: {prog_op, prog_type, prog_value} = {`MCI_OP_CONSTANT_A, 8'h09, 32'h0000_0005};
      16'h0001: {prog_op, prog_type, prog_value} = {`MCI_OP_CONSTANT_A_WITH_X, 8'h0A, 32'h0000_0000};
      16'h0002: {prog_op, prog_type, prog_value} = {`MCI_OP_CONSTANT_A, 8'h00, 32'h0000_0003};
      16'h0010: {prog_op, prog_type, prog_value} = {`MCI_OP_CONSTANT_A, 8'h09, 32'h0000_0077};
      16'h0011: {prog_op, prog_type, prog_value} = {`MCI_OP_RETURN_FROM_IRQ, 8'h00, 32'h0000_0000};
      default: {prog_op, prog_type, prog_value} = {`MCI_OP_END_PROGRAM, 8'h00, 32'h0000_0000};
    endcase
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: far-side model answers back end and program fetches
// Notes: one timer interrupt is taken in the middle of the stored program
`default_nettype none
`include "mci_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic host_valid = 1'b0;
  logic run = 1'b0;
  logic [7:0] host_op = 8'h00;
  logic [7:0] host_type = 8'h00;
  logic [31:0] host_value = 32'h0000_0000;
  logic host_reply_valid, running, be_valid, be_done;
  logic [7:0] host_status, prog_op, prog_type, prog_bank, out_pins;
  logic [31:0] host_reply, prog_value, be_result, accu, x_value;
  logic [15:0] pc;
  logic in_handler;
  logic [13:0] irq_event = 14'h0000;
  logic [5:0] in_pins = 6'h00;
  logic [7:0] st;
  logic [31:0] rep;
  int lat;
  int failures = 0;
  int n_compared = 0;
  always #50 clock = ~clock;
  mci_core dut (.clock(clock), .arst_n(arst_n), .host_valid(host_valid), .host_op(host_op),
    .host_type(host_type), .host_bank(8'h00), .host_value(host_value),
    .host_reply_valid(host_reply_valid), .host_status(host_status), .host_reply(host_reply),
    .run(run), .prog_op(prog_op), .prog_type(prog_type), .prog_bank(prog_bank),
    .prog_value(prog_value), .pc(pc), .running(running), .in_handler(in_handler),
    .be_valid(be_valid), .be_op(), .be_type(), .be_bank(), .be_value(), .be_done(be_done),
    .be_result(be_result), .irq_event(irq_event), .in_pins(in_pins), .out_pins(out_pins),
    .accu(accu), .x_value(x_value));
  mci_far_model far (.clock(clock), .be_valid(be_valid), .be_done(be_done),
    .be_result(be_result), .pc(pc), .prog_op(prog_op), .prog_type(prog_type),
    .prog_bank(prog_bank), .prog_value(prog_value));
  // Single comparison point keeps the counts honest
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Hold the command until the reply pulse is seen, then release
  task automatic host_cmd(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val);
    @(negedge clock);
    host_valid = 1'b1;
    host_op = op;
    host_type = typ;
    host_value = val;
    lat = 0;
    do begin
      @(posedge clock);
      #1;
      lat++;
    end while (host_reply_valid !== 1'b1 && lat < 60);
    if (lat >= 60) check(32'h0, 32'h1, "reply timeout");
    st = host_status;
    rep = host_reply;
    @(negedge clock);
    host_valid = 1'b0;
  endtask
  task automatic t_program();
    int n;
    logic seen = 1'b0;
    // Timer 0 slot vectors to the handler at 0x10
    host_cmd(`MCI_OP_SET_IRQ_VECTOR, 8'h00, 32'h0000_0010);
    check(32'(st), 32'(`MCI_ST_OK), "vector status");
    host_cmd(`MCI_OP_IRQ_ENABLE, 8'h00, 32'h0000_0000);
    host_cmd(`MCI_OP_IRQ_ENABLE, `MCI_IRQ_GLOBAL, 32'h0000_0000);
    check(32'(st), 32'(`MCI_ST_OK), "global enable status");
    @(negedge clock);
    run = 1'b1;
    for (n = 0; n < 60 && running !== 1'b1; n++) @(posedge clock);
    // One-cycle timer event while the main program runs
    @(negedge clock);
    irq_event = 14'h0001;
    @(negedge clock);
    irq_event = 14'h0000;
    for (n = 0; n < 200 && running !== 1'b0; n++) begin
      @(posedge clock);
      seen = seen | in_handler;
    end
    @(negedge clock);
    run = 1'b0;
    check(32'(seen), 32'h0000_0001, "handler entered");
    check(32'(in_handler), 32'h0000_0000, "handler left");
    check(accu, 32'h0000_0008, "accu after program");
    check(x_value, 32'h0000_0005, "x after program");
    $display("test program done");
  endtask
  task automatic t_output();
    host_cmd(`MCI_OP_SET_OUTPUT, 8'h03, 32'h0000_0001);
    check(32'(out_pins), 32'h0000_0008, "output pin set");
    check(32'(st), 32'(`MCI_ST_OK), "output status");
    check(lat, 2, "output latency");
    in_pins = 6'h2D;
    host_cmd(`MCI_OP_GET_INPUT, 8'h00, 32'h0000_0000);
    check(rep, 32'h0000_002D, "input read");
    $display("test output done");
  endtask
  task automatic t_refuse();
    logic [7:0] flow [7] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1B, 8'h1C};
    host_cmd(8'h07, 8'h00, 32'h0000_0000);
    check(32'(st), 32'(`MCI_ST_BAD_OP), "unknown status");
    check(accu, 32'h0000_0008, "unknown keeps accu");
    check(32'(out_pins), 32'h0000_0008, "unknown keeps pins");
    foreach (flow[i]) begin
      host_cmd(flow[i], 8'h00, 32'h0000_0005);
      check(32'(st), 32'(`MCI_ST_BAD_MODE), "flow from host");
    end
    check(32'(pc), 32'h0000_0000, "pc left alone");
    $display("test refuse done");
  endtask
  task automatic t_query();
    logic [7:0] ops [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09};
    host_cmd(`MCI_OP_GET_AXIS_PARAM, 8'h01, 32'h0000_0000);
    check(rep, 32'h1234_5678, "query reply");
    check(accu, 32'h0000_0008, "query keeps accu");
    foreach (ops[i]) begin
      host_cmd(ops[i], 8'h00, 32'h0000_0010);
      check(32'(st), 32'(`MCI_ST_OK), "motion or param ok");
    end
    $display("test query done");
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: whole run needs well under 2000 cycles
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    t_program();
    t_output();
    t_refuse();
    t_query();
    stop_test();
  end
endmodule
`default_nettype wire
